// *** design/scr_defines.svh ***
// register offsets, field positions and counts of the serial receive slice
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ==========================================
// register offsets
`define SCR_AW 3
`define SCR_OFS_CTL1 3'h0
`define SCR_OFS_CTL2 3'h1
`define SCR_OFS_CTL3 3'h2
`define SCR_OFS_STAT 3'h3
`define SCR_OFS_DATA 3'h4
`define SCR_OFS_IRC 3'h5

// ==========================================
// control_reg_one fields
`define SCR_C1_LOOP 7
`define SCR_C1_MODEN 6
`define SCR_C1_LEN9 4
`define SCR_C1_WAKE 3
`define SCR_C1_PEN 1
`define SCR_C1_PODD 0

// ==========================================
// control_reg_two fields
`define SCR_C2_RXFIE 5
`define SCR_C2_IDLIE 4
`define SCR_C2_TXEN 3
`define SCR_C2_RXEN 2
`define SCR_C2_STBY 1

// ==========================================
// control_reg_three fields
`define SCR_C3_R8 7
`define SCR_C3_OVERRUN_IRQ_EN 3
`define SCR_C3_NOISE_IRQ_EN 2
`define SCR_C3_FRAMING_IRQ_EN 1
`define SCR_C3_PARITY_IRQ_EN 0

// ==========================================
// status_reg_one fields
`define SCR_S_TXE 7
`define SCR_S_TC 6
`define SCR_S_RXF 5
`define SCR_S_IDLE 4
`define SCR_S_OR 3
`define SCR_S_NF 2
`define SCR_S_FE 1
`define SCR_S_PE 0

// ==========================================
// infrared_control_reg field
`define SCR_IR_EN 0

// ==========================================
// reset values and counts
`define SCR_RST8 8'h00
`define SCR_RT_W 4
`define SCR_RT_FIRST 4'h1
`define SCR_RT_S1 4'h8
`define SCR_RT_S2 4'h9
`define SCR_RT_S3 4'hA
`define SCR_RT_END 4'h0
`define SCR_RT_PER_BIT 16
`define SCR_IDLE_BITS8 10
`define SCR_IDLE_BITS9 11
`define SCR_DBITS8 4'h8
`define SCR_DBITS9 4'h9

`endif

// *** design/scr_pkg.sv ***
// types of the serial receive slice
package scr_pkg;
    typedef enum logic [3:0] {
        st_hunt = 4'h1,
        st_start = 4'h2,
        st_data = 4'h4,
        st_stop = 4'h8
    } scr_rx_state_t;
endpackage : scr_pkg

// *** design/scr_bit_sampler.sv ***
// 16x oversampled bit recovery with three-sample majority and noise
`timescale 1ns/1ns
`include "scr_defines.svh"
module scr_bit_sampler (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic rt_tick_in,
    input wire logic line_in,
    input wire logic arm_in,
    input wire logic frame_end_in,
    output logic busy_out,
    output logic bit_done_out,
    output logic bit_val_out,
    output logic bit_noise_out
);
    logic busy;
    logic prev_line;
    logic [`SCR_RT_W-1:0] rt;
    logic samp_a;
    logic samp_b;
    logic bit_val;
    logic bit_noise;
    wire fall = arm_in & ~busy & rt_tick_in & prev_line & ~line_in;
    wire step = busy & rt_tick_in;
    wire maj = (samp_a & samp_b) | (samp_a & line_in) | (samp_b & line_in);
    wire agree = (samp_a == samp_b) & (samp_b == line_in);

    assign busy_out = busy;
    assign bit_done_out = step & (rt == `SCR_RT_END);
    assign bit_val_out = bit_val;
    assign bit_noise_out = bit_noise;

    // ==========================================
    // edge hunt and RT count
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy <= 1'b0;
            prev_line <= 1'b1;
            rt <= `SCR_RT_END;
        end else begin
            if (rt_tick_in)
                prev_line <= line_in;
            if (!arm_in || frame_end_in)
                busy <= 1'b0;
            else if (fall)
                busy <= 1'b1;
            if (fall)
                rt <= `SCR_RT_FIRST;
            else if (step)
                rt <= rt + `SCR_RT_FIRST;
        end
    end

    // ==========================================
    // samples at RT8, RT9, RT10
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            samp_a <= 1'b1;
            samp_b <= 1'b1;
            bit_val <= 1'b1;
            bit_noise <= 1'b0;
        end else if (step) begin
            if (rt == `SCR_RT_S1)
                samp_a <= line_in;
            if (rt == `SCR_RT_S2)
                samp_b <= line_in;
            if (rt == `SCR_RT_S3) begin
                bit_val <= maj;
                bit_noise <= ~agree;
            end
        end
    end
endmodule : scr_bit_sampler

// *** design/scr_rx_events.sv ***
// serial receiver events, error flags, pin ownership and control register one
// ==========================================
// Overview of operation
// - completed character sets receive-full, irq if enabled
// - idle after 10 or 11 ones
// - overrun keeps old character, drops new
// - overrun error irq gated by its enable
// - noise on start, data, stop sets noise
// - noise error irq gated by its enable
// - zero at stop bit sets framing error
// - parity check failure sets parity error
// - wait mode: runs, registers inaccessible, irqs wake
// - stop mode halts, keeps registers
// - break without clear-enable: reads clear no flags
// - two-step clear finishes only after break
// - clear-enable lets flags clear during break
// - enabled module owns both pin directions
// - transmit pin idles high, infrared, hi-z
// - receive pin sampled only when receiver enabled
// - module disabled returns pins to port
// - loop feeds transmitter into receiver
// - module enable; clearing forces transmit flags
// - length bit picks 9 or 8 bits
// - wake bit: address mark or idle line
// - reset clears control register one bits
// - standby suppresses receiver irqs until wakeup
// - wakeup effects on receive-full and idle
`timescale 1ns/1ns
`include "scr_defines.svh"
module scr_rx_events (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [`SCR_AW-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic rt_tick_in,
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic debug_break_in,
    input wire logic break_clear_en_in,
    input wire logic tx_serial_in,
    input wire logic tx_ir_in,
    input wire logic tx_busy_in,
    input wire logic tx_empty_in,
    input wire logic tx_complete_in,
    input wire logic tx_irq_req_in,
    input wire logic ir_rx_decoded_in,
    input wire logic port_b0_data_in,
    input wire logic port_b0_dir_in,
    input wire logic port_b1_data_in,
    input wire logic port_b1_dir_in,
    input wire logic port_b1_in,
    output logic port_b0_out,
    output logic port_b0_oe_out,
    output logic port_b1_out,
    output logic port_b1_oe_out,
    output logic baud_en_out,
    output logic tx_flags_force_out,
    output logic rx_irq_out,
    output logic err_irq_out,
    output logic tx_irq_out
);
    // ==========================================
    // registers
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic [7:0] control_reg_three;
    logic [7:0] infrared_control_reg;
    logic [7:0] data_reg;
    logic rx_bit8;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic clear_armed;
    logic [7:0] rdata;
    logic b1_meta;
    logic b1_sync;
    logic b0_out;
    logic b0_oe;
    logic b1_out;
    logic b1_oe;

    // ==========================================
    // receiver state
    scr_pkg::scr_rx_state_t state;
    scr_pkg::scr_rx_state_t next_state;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic frame_noise;
    logic [7:0] idle_cnt;
    logic idle_armed;

    // ==========================================
    // control fields
    wire loopback_sel = control_reg_one[`SCR_C1_LOOP];
    wire module_en = control_reg_one[`SCR_C1_MODEN];
    wire len9 = control_reg_one[`SCR_C1_LEN9];
    wire wake_addr = control_reg_one[`SCR_C1_WAKE];
    wire parity_en = control_reg_one[`SCR_C1_PEN];
    wire parity_odd = control_reg_one[`SCR_C1_PODD];
    wire rx_full_irq_en = control_reg_two[`SCR_C2_RXFIE];
    wire idle_irq_en = control_reg_two[`SCR_C2_IDLIE];
    wire tx_en = control_reg_two[`SCR_C2_TXEN];
    wire rx_en = control_reg_two[`SCR_C2_RXEN];
    wire rx_standby = control_reg_two[`SCR_C2_STBY];
    wire overrun_irq_en = control_reg_three[`SCR_C3_OVERRUN_IRQ_EN];
    wire noise_irq_en = control_reg_three[`SCR_C3_NOISE_IRQ_EN];
    wire framing_irq_en = control_reg_three[`SCR_C3_FRAMING_IRQ_EN];
    wire parity_irq_en = control_reg_three[`SCR_C3_PARITY_IRQ_EN];
    wire infrared_en = infrared_control_reg[`SCR_IR_EN];

    // ==========================================
    // bus decode; cpu cannot reach registers in wait mode
    wire acc_wr = reg_wr_in & ~wait_mode_in;
    wire acc_rd = reg_rd_in & ~wait_mode_in;
    wire sel_c1 = reg_addr_in == `SCR_OFS_CTL1;
    wire sel_c2 = reg_addr_in == `SCR_OFS_CTL2;
    wire sel_c3 = reg_addr_in == `SCR_OFS_CTL3;
    wire sel_st = reg_addr_in == `SCR_OFS_STAT;
    wire sel_dr = reg_addr_in == `SCR_OFS_DATA;
    wire sel_ir = reg_addr_in == `SCR_OFS_IRC;
    // break protection: flags may clear only outside break or with enable
    wire clr_ok = ~debug_break_in | break_clear_en_in;
    wire arm_step = acc_rd & sel_st & clr_ok;
    wire clr_step = acc_rd & sel_dr & clear_armed & clr_ok;

    // ==========================================
    // receive line selection
    wire pin_line = infrared_en ? ir_rx_decoded_in : b1_sync;
    // loop bypasses the infrared path and the pin
    wire rx_line = loopback_sel ? tx_serial_in : pin_line;
    // stop mode halts the receiver; a frame in flight is lost
    wire rx_active = module_en & rx_en & ~stop_mode_in;

    wire samp_busy;
    wire bit_done;
    wire bit_val;
    wire bit_noise;
    wire [3:0] dbits = len9 ? `SCR_DBITS9 : `SCR_DBITS8;
    wire false_start = bit_done & (state == scr_pkg::st_start) & bit_val;
    wire stop_done = bit_done & (state == scr_pkg::st_stop);
    wire frame_end = false_start | stop_done;

    scr_bit_sampler u_sampler (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .rt_tick_in(rt_tick_in),
        .line_in(rx_line),
        .arm_in(rx_active),
        .frame_end_in(frame_end),
        .busy_out(samp_busy),
        .bit_done_out(bit_done),
        .bit_val_out(bit_val),
        .bit_noise_out(bit_noise)
    );

    // ==========================================
    // character completion
    wire [8:0] rx_char = len9 ? shift : {1'b0, shift[8:1]};
    wire char_msb = len9 ? shift[8] : shift[7];
    wire par_bad = parity_en & ((^rx_char) != parity_odd);
    wire frame_bad = ~bit_val;
    wire mark_wake = rx_standby & wake_addr & char_msb;
    // in standby, characters without an address mark are dropped
    wire char_take = stop_done & (~rx_standby | mark_wake);
    wire char_new = char_take & ~rx_full_flag;
    wire char_lost = char_take & rx_full_flag;

    // ==========================================
    // idle line detection
    wire [7:0] idle_ticks = len9 ?
        8'(`SCR_IDLE_BITS9 * `SCR_RT_PER_BIT) :
        8'(`SCR_IDLE_BITS8 * `SCR_RT_PER_BIT);
    wire line_quiet = rx_active & ~samp_busy & rx_line;
    wire idle_hit = line_quiet & rt_tick_in & idle_armed &
        (idle_cnt == idle_ticks - 8'h01);
    // the idle character that wakes standby sets no idle flag
    wire idle_wake = idle_hit & rx_standby & ~wake_addr;
    wire idle_set = idle_hit & ~rx_standby;

    // ==========================================
    // frame sequencing
    always_comb begin
        next_state = state;
        case (state)
            scr_pkg::st_hunt: begin
                if (samp_busy)
                    next_state = scr_pkg::st_start;
            end
            scr_pkg::st_start: begin
                if (!samp_busy || false_start)
                    next_state = scr_pkg::st_hunt;
                else if (bit_done)
                    next_state = scr_pkg::st_data;
            end
            scr_pkg::st_data: begin
                if (!samp_busy)
                    next_state = scr_pkg::st_hunt;
                else if (bit_done && bit_cnt == dbits)
                    next_state = scr_pkg::st_stop;
            end
            scr_pkg::st_stop: begin
                if (!samp_busy || bit_done)
                    next_state = scr_pkg::st_hunt;
            end
            default: next_state = scr_pkg::st_hunt;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= scr_pkg::st_hunt;
            bit_cnt <= 4'h0;
            shift <= 9'h000;
            frame_noise <= 1'b0;
        end else begin
            state <= next_state;
            if (state == scr_pkg::st_hunt)
                bit_cnt <= 4'h0;
            else if (bit_done)
                bit_cnt <= bit_cnt + 4'h1;
            if (bit_done && state == scr_pkg::st_data)
                shift <= {bit_val, shift[8:1]};
            // noise on any bit, start through stop, breaks included
            if (state == scr_pkg::st_hunt)
                frame_noise <= 1'b0;
            else if (bit_done && bit_noise)
                frame_noise <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idle_cnt <= 8'h00;
            idle_armed <= 1'b0;
        end else begin
            if (!line_quiet)
                idle_cnt <= 8'h00;
            else if (rt_tick_in && idle_cnt != idle_ticks)
                idle_cnt <= idle_cnt + 8'h01;
            // one idle report per quiet spell, rearmed by a character
            if (stop_done)
                idle_armed <= 1'b1;
            else if (idle_hit)
                idle_armed <= 1'b0;
        end
    end

    // ==========================================
    // status flags: a hardware set wins over a clear
    wire err_noise = stop_done & (frame_noise | bit_noise);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_full_flag <= 1'b0;
            idle_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_err_flag <= 1'b0;
            parity_err_flag <= 1'b0;
            clear_armed <= 1'b0;
        end else begin
            rx_full_flag <= char_new | (rx_full_flag & ~clr_step);
            idle_flag <= idle_set | (idle_flag & ~clr_step);
            overrun_flag <= char_lost |
                (overrun_flag & ~clr_step);
            noise_flag <= (char_take & err_noise) |
                (noise_flag & ~clr_step);
            framing_err_flag <= (char_take & frame_bad) |
                (framing_err_flag & ~clr_step);
            parity_err_flag <= (char_take & par_bad) |
                (parity_err_flag & ~clr_step);
            // first step survives break; second step waits for its end
            if (arm_step)
                clear_armed <= 1'b1;
            else if (clr_step)
                clear_armed <= 1'b0;
        end
    end

    // ==========================================
    // data register: older character kept on overrun
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_reg <= `SCR_RST8;
            rx_bit8 <= 1'b0;
        end else if (char_new) begin
            data_reg <= rx_char[7:0];
            rx_bit8 <= len9 ? rx_char[8] : rx_char[7];
        end
    end

    // ==========================================
    // control registers
    wire [7:0] c2_keep = control_reg_two &
        8'((1 << `SCR_C2_TXEN) | (1 << `SCR_C2_RXEN));
    // enables of transmitter and receiver take writes only when enabled
    wire [7:0] c2_wr = module_en ? reg_wdata_in :
        ((reg_wdata_in & ~8'((1 << `SCR_C2_TXEN) | (1 << `SCR_C2_RXEN)))
        | c2_keep);
    wire stby_wake = mark_wake & stop_done | idle_wake;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            control_reg_one <= `SCR_RST8;
            control_reg_two <= `SCR_RST8;
            control_reg_three <= `SCR_RST8;
            infrared_control_reg <= `SCR_RST8;
        end else begin
            if (acc_wr && sel_c1)
                control_reg_one <= reg_wdata_in;
            if (acc_wr && sel_c2)
                control_reg_two <= c2_wr;
            else if (stby_wake)
                control_reg_two[`SCR_C2_STBY] <= 1'b0;
            if (acc_wr && sel_c3)
                control_reg_three <= reg_wdata_in;
            if (acc_wr && sel_ir)
                infrared_control_reg <= reg_wdata_in;
        end
    end

    // ==========================================
    // read path, one cycle latency
    wire [7:0] stat_rd = {tx_empty_in | ~module_en,
        tx_complete_in | ~module_en, rx_full_flag, idle_flag,
        overrun_flag, noise_flag, framing_err_flag, parity_err_flag};
    wire [7:0] c3_rd = {rx_bit8, control_reg_three[6:0]};
    wire [7:0] rd_mux = sel_c1 ? control_reg_one :
        sel_c2 ? control_reg_two :
        sel_c3 ? c3_rd :
        sel_st ? stat_rd :
        sel_dr ? data_reg :
        sel_ir ? infrared_control_reg : `SCR_RST8;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            rdata <= `SCR_RST8;
        else if (acc_rd)
            rdata <= rd_mux;
        else
            rdata <= `SCR_RST8;
    end

    // ==========================================
    // pins; port logic owns both while the module is off
    wire tx_drive = tx_en | tx_busy_in;
    wire tx_level = infrared_en ? tx_ir_in : tx_serial_in;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            b1_meta <= 1'b1;
            b1_sync <= 1'b1;
            b0_out <= 1'b0;
            b0_oe <= 1'b0;
            b1_out <= 1'b0;
            b1_oe <= 1'b0;
        end else begin
            b1_meta <= port_b1_in;
            b1_sync <= b1_meta;
            if (module_en) begin
                b0_out <= tx_drive ? tx_level : 1'b1;
                b0_oe <= tx_drive;
                b1_out <= 1'b0;
                b1_oe <= 1'b0;
            end else begin
                b0_out <= port_b0_data_in;
                b0_oe <= port_b0_dir_in;
                b1_out <= port_b1_data_in;
                b1_oe <= port_b1_dir_in;
            end
        end
    end

    // ==========================================
    // interrupt requests are plain levels of flag and enable
    wire rx_req = (rx_full_flag & rx_full_irq_en) |
        (idle_flag & idle_irq_en);
    wire err_req = (overrun_flag & overrun_irq_en) |
        (noise_flag & noise_irq_en) |
        (framing_err_flag & framing_irq_en) |
        (parity_err_flag & parity_irq_en);

    assign reg_rdata_out = rdata;
    assign port_b0_out = b0_out;
    assign port_b0_oe_out = b0_oe;
    assign port_b1_out = b1_out;
    assign port_b1_oe_out = b1_oe;
    assign baud_en_out = module_en;
    assign tx_flags_force_out = ~module_en;
    assign rx_irq_out = rx_req & ~rx_standby;
    assign err_irq_out = err_req;
    assign tx_irq_out = tx_irq_req_in & module_en;
endmodule : scr_rx_events

// *** test/scr_rx_events_monitor.sv ***
// port checker of the serial receive slice
`timescale 1ns/1ns
`include "scr_defines.svh"
module scr_rx_events_monitor (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [`SCR_AW-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic wait_mode_in,
    input wire logic debug_break_in,
    input wire logic break_clear_en_in,
    input wire logic tx_serial_in,
    input wire logic tx_ir_in,
    input wire logic tx_busy_in,
    input wire logic tx_irq_req_in,
    input wire logic port_b0_dir_in,
    input wire logic port_b1_dir_in,
    input wire logic port_b0_out,
    input wire logic port_b0_oe_out,
    input wire logic port_b1_oe_out,
    input wire logic baud_en_out,
    input wire logic tx_flags_force_out,
    input wire logic rx_irq_out,
    input wire logic err_irq_out,
    input wire logic tx_irq_out
);
    // ====
    // assertions
    wire ok_clr = !wait_mode_in && (!debug_break_in || break_clear_en_in);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    a_tx_irq_gate: assert property (
        tx_irq_out == (tx_irq_req_in && baud_en_out))
        else $error("tx irq not gated");
    a_flag_force: assert property (
        tx_flags_force_out == !baud_en_out)
        else $error("tx flag force wrong");
    a_wait_read: assert property (
        reg_rd_in && wait_mode_in |=> reg_rdata_out == 8'h00)
        else $error("read answered in wait");
    a_wait_write: assert property (
        reg_wr_in && wait_mode_in |=> $stable(baud_en_out))
        else $error("write taken in wait");
    a_rx_pin_in: assert property (
        $past(resetn_in && baud_en_out) |-> !port_b1_oe_out)
        else $error("receive pin driven");
    a_port_pass: assert property (
        $past(resetn_in && !baud_en_out) |->
        port_b0_oe_out == $past(port_b0_dir_in) &&
        port_b1_oe_out == $past(port_b1_dir_in))
        else $error("pins not under port control");
    a_tx_drive: assert property (
        $past(resetn_in && baud_en_out && tx_busy_in && tx_serial_in &&
        tx_ir_in) |-> port_b0_oe_out && port_b0_out)
        else $error("transmit pin not driven high");
    a_break_hold: assert property (
        debug_break_in && !break_clear_en_in && reg_rd_in && !wait_mode_in
        |=> !$fell(rx_irq_out) && !$fell(err_irq_out))
        else $error("flag changed in break");
    a_read_clears: assert property (
        reg_rd_in && reg_addr_in == `SCR_OFS_STAT && ok_clr ##1
        reg_rd_in && reg_addr_in == `SCR_OFS_DATA && ok_clr
        |=> !rx_irq_out && !err_irq_out)
        else $error("flags not cleared by read pair");
    c_rx_irq: cover property ($rose(rx_irq_out));
    c_err_irq: cover property ($rose(err_irq_out));
    c_wait_rd: cover property (reg_rd_in && wait_mode_in);
endmodule : scr_rx_events_monitor

bind scr_rx_events scr_rx_events_monitor scr_rx_events_monitor_i (.*);

// *** test/scr_remote_tx.sv ***
// remote serial transmitter on the receive pin, 16 clocks a bit
`timescale 1ns/1ns
module scr_remote_tx (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [9:0] frame_in,
    output logic line_out
);
    logic [9:0] sh = 10'h3FF;
    logic [7:0] cnt = 8'h00;
    logic busy = 1'b0;
    // ====
    // frame shifter, lsb first
    always @(posedge clk_in) begin
        if (go_in && !busy) begin
            sh <= frame_in;
            cnt <= 8'h00;
            busy <= 1'b1;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
            busy <= (cnt != 8'h9F);
        end
    end
    // pull-up holds the line high between frames
    assign line_out = busy ? sh[cnt[7:4]] : 1'b1;
endmodule : scr_remote_tx

// *** test/scr_rx_events_test.sv ***
// self-checking bench of the serial receive slice
`timescale 1ns/1ns
`include "scr_defines.svh"
module scr_rx_events_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, wt = 1'b0, dbg = 1'b0, bce = 1'b0;
    logic txl = 1'b1, busy = 1'b0, txreq = 1'b0, go = 1'b0;
    logic pd0 = 1'b0, pr0 = 1'b0, pr1 = 1'b0;
    logic [9:0] fr = 10'h3FF;
    logic [7:0] rdata, d;
    logic b1_in, b0, b0_oe, b1, b1_oe, baud, force_tx, rxi, erri, txi;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    scr_rx_events scr_rx_events_i (
        .core_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .rt_tick_in(1'b1), .wait_mode_in(wt),
        .stop_mode_in(1'b0), .debug_break_in(dbg),
        .break_clear_en_in(bce), .tx_serial_in(txl), .tx_ir_in(txl),
        .tx_busy_in(busy), .tx_empty_in(1'b0), .tx_complete_in(1'b0),
        .tx_irq_req_in(txreq), .ir_rx_decoded_in(1'b1),
        .port_b0_data_in(pd0), .port_b0_dir_in(pr0),
        .port_b1_data_in(pr1), .port_b1_dir_in(pr1), .port_b1_in(b1_in),
        .port_b0_out(b0), .port_b0_oe_out(b0_oe), .port_b1_out(b1),
        .port_b1_oe_out(b1_oe), .baud_en_out(baud),
        .tx_flags_force_out(force_tx), .rx_irq_out(rxi),
        .err_irq_out(erri), .tx_irq_out(txi));
    scr_remote_tx scr_remote_tx_i (.clk_in(clk), .go_in(go),
        .frame_in(fr), .line_out(b1_in));
    initial forever #5 clk = ~clk;
    // ====
    // bus and check tasks
    task chk(input string what, input logic [7:0] got, input logic [7:0] e);
        n_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd_reg
    task rc(input logic [2:0] a, input logic [7:0] e, input string what);
        rd_reg(a, d);
        chk(what, d, e);
    endtask : rc
    task clr;
        @(posedge clk);
        addr <= `SCR_OFS_STAT;
        rd <= 1'b1;
        @(posedge clk);
        addr <= `SCR_OFS_DATA;
        @(posedge clk);
        rd <= 1'b0;
    endtask : clr
    task flush;
        repeat (200) @(posedge clk);
        clr();
    endtask : flush
    task send(input logic [9:0] f);
        fr <= f;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (184) @(posedge clk);
    endtask : send
    // ====
    // scenarios
    task t_reset;
        rc(`SCR_OFS_CTL1, 8'h00, "ctrl1 reset");
        rc(`SCR_OFS_STAT, 8'hC0, "status off");
        chk("tx force", 8'(force_tx), 8'h01);
    endtask : t_reset
    task t_pins;
        pr0 <= 1'b1;
        pr1 <= 1'b1;
        txreq <= 1'b1;
        repeat (2) @(posedge clk);
        chk("b0 port", {6'h00, b0, b0_oe}, 8'h01);
        chk("b1 port", {6'h00, b1, b1_oe}, 8'h03);
        chk("tx irq off", 8'(txi), 8'h00);
        wr_reg(`SCR_OFS_CTL1, 8'h40);
        wr_reg(`SCR_OFS_CTL2, 8'h2C);
        wr_reg(`SCR_OFS_CTL3, 8'h0F);
        busy <= 1'b1;
        repeat (2) @(posedge clk);
        chk("b0 drive", {6'h00, b0, b0_oe}, 8'h03);
        chk("b1 input", 8'(b1_oe), 8'h00);
        chk("tx irq on", 8'(txi), 8'h01);
        busy <= 1'b0;
    endtask : t_pins
    task t_char;
        send({1'b1, 8'hA5, 1'b0});
        rc(`SCR_OFS_STAT, 8'h20, "rx full");
        chk("rx irq", 8'(rxi), 8'h01);
        rc(`SCR_OFS_DATA, 8'hA5, "rx data");
        chk("rx irq clr", 8'(rxi), 8'h00);
        repeat (200) @(posedge clk);
        rc(`SCR_OFS_STAT, 8'h10, "idle");
        clr();
    endtask : t_char
    task t_errors;
        send({1'b1, 8'h3C, 1'b0});
        send({1'b1, 8'h5A, 1'b0});
        rc(`SCR_OFS_STAT, 8'h28, "overrun");
        chk("err irq or", 8'(erri), 8'h01);
        rc(`SCR_OFS_DATA, 8'h3C, "old kept");
        chk("err irq clr", 8'(erri), 8'h00);
        flush();
        send({1'b0, 8'h55, 1'b0});
        rc(`SCR_OFS_STAT, 8'h22, "framing");
        chk("err irq fe", 8'(erri), 8'h01);
        flush();
        wr_reg(`SCR_OFS_CTL1, 8'h42);
        send({1'b1, 8'h01, 1'b0});
        rc(`SCR_OFS_STAT, 8'h21, "parity");
        wr_reg(`SCR_OFS_CTL1, 8'h40);
        flush();
    endtask : t_errors
    task t_break;
        send({1'b1, 8'h77, 1'b0});
        rd_reg(`SCR_OFS_STAT, d);
        dbg <= 1'b1;
        rc(`SCR_OFS_DATA, 8'h77, "break read");
        rc(`SCR_OFS_STAT, 8'h20, "break hold");
        dbg <= 1'b0;
        rc(`SCR_OFS_DATA, 8'h77, "data after");
        rc(`SCR_OFS_STAT, 8'h00, "clear after");
        flush();
        send({1'b1, 8'h66, 1'b0});
        dbg <= 1'b1;
        bce <= 1'b1;
        clr();
        dbg <= 1'b0;
        bce <= 1'b0;
        rc(`SCR_OFS_STAT, 8'h00, "bce clear");
        wt <= 1'b1;
        wr_reg(`SCR_OFS_CTL1, 8'h00);
        rc(`SCR_OFS_CTL1, 8'h00, "wait read");
        wt <= 1'b0;
        chk("wait write", 8'(baud), 8'h01);
    endtask : t_break
    task final_report;
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_pins();
        t_char();
        t_errors();
        t_break();
        final_report();
    end
endmodule : scr_rx_events_test
